// File: lcirq_regs.sv
// Link configuration and interrupt registers behind a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module lcirq_regs
#(
    // Cycles per microsecond; lower it to shorten latency counts in simulation
    parameter int LAT_CYC_PER_US = lcirq_pkg::CYC_PER_US
)
(
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Event pulses from the link logic, same clock
    input wire logic ev_link_broken_i,
    input wire logic ev_poor_link_i,
    input wire logic ev_xfer_done_i,
    input wire logic ev_input_chg_i,
    // Role strap pin, high in the audio_transmitter_role
    input wire logic audio_transmitter_role_i,
    // Audio sample rate select, same clock
    input wire logic [1:0] fs_sel_i,
    // Interrupt pin, level set by polarity
    output logic irq_o,
    output logic irq_oe_o,
    // Internal interrupt, active high
    output logic int_o,
    // Configuration outputs to the link
    output logic [1:0] latency_code_o,
    output logic [23:0] latency_cycles_o,
    output logic [1:0] tx_power_code_o,
    output logic [1:0] rx_power_code_o,
    output logic [5:0] tx_power_dbm_o,
    output logic [5:0] rx_power_dbm_o
);
    // Bus state
    lcirq_pkg::lcirq_bus_e bus_r;
    lcirq_pkg::lcirq_bus_e bus_nxt;
    // Registers
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] lat_r;
    logic [7:0] cfg_r;
    logic [7:0] txp_r;
    logic [7:0] rxp_r;
    // Read data and derived outputs
    logic [31:0] rdat_r;
    logic irq_r;
    logic irq_oe_r;
    logic int_r;
    logic [23:0] lat_cyc_r;
    logic [5:0] txdbm_r;
    logic [5:0] rxdbm_r;
    // Synchronised role strap
    logic role_tx;

    // Power code to dBm; used for both ends
    function automatic logic [5:0] pwr_dbm(input logic [1:0] code);
        logic [5:0] d;
        d = lcirq_pkg::DBM_CODE3;
        case (code)
            2'h0: d = lcirq_pkg::DBM_CODE0;
            2'h1: d = lcirq_pkg::DBM_CODE1;
            2'h2: d = lcirq_pkg::DBM_CODE2;
            default: d = lcirq_pkg::DBM_CODE3;
        endcase
        return d;
    endfunction : pwr_dbm

    // Delay in microseconds for a code and a sample rate
    function automatic logic [14:0] lat_us(input logic [1:0] code, input logic [1:0] fs);
        logic [14:0] u;
        u = lcirq_pkg::DLY_NOM_48_US;
        case (code)
            lcirq_pkg::LAT_HIGH:
                u = (fs == lcirq_pkg::FS_32K) ? lcirq_pkg::DLY_HIGH_32_US :
                    (fs == lcirq_pkg::FS_44K1) ? lcirq_pkg::DLY_HIGH_44_US :
                    lcirq_pkg::DLY_HIGH_48_US;
            lcirq_pkg::LAT_SHORT:
                u = (fs == lcirq_pkg::FS_32K) ? lcirq_pkg::DLY_SHORT_32_US :
                    (fs == lcirq_pkg::FS_44K1) ? lcirq_pkg::DLY_SHORT_44_US :
                    lcirq_pkg::DLY_SHORT_48_US;
            // Code 3 is undefined; it falls back to nominal
            default:
                u = (fs == lcirq_pkg::FS_32K) ? lcirq_pkg::DLY_NOM_32_US :
                    (fs == lcirq_pkg::FS_44K1) ? lcirq_pkg::DLY_NOM_44_US :
                    lcirq_pkg::DLY_NOM_48_US;
        endcase
        return u;
    endfunction : lat_us

    // Role strap comes from a pin, so it is synchronised first
    lcirq_sync u_role_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(audio_transmitter_role_i),
        .q_o(role_tx)
    );

    // Request taken in idle, so each request is answered once
    wire req = wb_cyc_i && wb_stb_i && (bus_r == lcirq_pkg::BUS_IDLE);
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire rd = req && !wb_we_i;
    // Register index from the word address
    wire [7:0] idx = wb_adr_i[9:2];
    wire hit_flags = (idx == lcirq_pkg::IDX_INT_FLAGS);
    wire hit_lat = (idx == lcirq_pkg::IDX_LAT_SEL);
    wire hit_cfg = (idx == lcirq_pkg::IDX_INT_CFG);
    wire hit_txp = (idx == lcirq_pkg::IDX_TX_PWR);
    wire hit_rxp = (idx == lcirq_pkg::IDX_RX_PWR);

    // Read mux; unmapped addresses return zero
    wire [7:0] rsel = hit_flags ? (flags_r & lcirq_pkg::MASK_EVENTS) :
        hit_lat ? lat_r :
        hit_cfg ? (cfg_r & lcirq_pkg::MASK_CFG) :
        hit_txp ? txp_r :
        hit_rxp ? rxp_r : 8'h00;

    // Incoming event pulses in flag layout
    wire [7:0] ev_set = {1'b0, ev_link_broken_i, ev_poor_link_i,
        ev_xfer_done_i, ev_input_chg_i, 3'h0};
    // A flag read clears exactly the bits it returned
    wire [7:0] rd_clr = (rd && hit_flags) ? flags_r : 8'h00;

    // New events win over the read clear, so none is lost
    assign flags_nxt = ((flags_r & ~rd_clr) | ev_set) & lcirq_pkg::MASK_EVENTS;

    // Enabled and pending events
    wire pending = |(flags_nxt & cfg_r & lcirq_pkg::MASK_EVENTS);
    wire polarity = cfg_r[lcirq_pkg::BIT_POLARITY];
    // Pin level: active level while pending, the opposite otherwise
    wire irq_lvl = pending ? polarity : ~polarity;

    // Bus state: answer one cycle after the request, then drop ack
    assign bus_nxt = (bus_r == lcirq_pkg::BUS_IDLE) ?
        (req ? lcirq_pkg::BUS_ACK : lcirq_pkg::BUS_IDLE) : lcirq_pkg::BUS_IDLE;

    // Bus state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bus_r <= lcirq_pkg::BUS_IDLE;
        else if (ce_i)
        begin
            case (bus_r)
                lcirq_pkg::BUS_IDLE: bus_r <= bus_nxt;
                lcirq_pkg::BUS_ACK: bus_r <= bus_nxt;
                default: bus_r <= lcirq_pkg::BUS_IDLE;
            endcase
        end
    end

    // Read data is held until the next read so the master sees it with ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_r <= 32'h0000_0000;
        else if (ce_i && rd)
            rdat_r <= {24'h00_0000, rsel};
    end

    // Sticky event flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_r <= lcirq_pkg::RST_INT_FLAGS;
        else if (ce_i)
            flags_r <= flags_nxt;
    end

    // Latency select keeps the full byte written
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lat_r <= lcirq_pkg::RST_LAT_SEL;
        else if (ce_i && wr && hit_lat)
            lat_r <= wb_dat_i[7:0];
    end

    // Interrupt config; reserved low bits are not stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_r <= lcirq_pkg::RST_INT_CFG;
        else if (ce_i && wr && hit_cfg)
            cfg_r <= wb_dat_i[7:0] & lcirq_pkg::MASK_CFG;
    end

    // Transmitter power select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            txp_r <= lcirq_pkg::RST_TX_PWR;
        else if (ce_i && wr && hit_txp)
            txp_r <= wb_dat_i[7:0];
    end

    // Receiver power select, reached from this same port
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rxp_r <= lcirq_pkg::RST_RX_PWR;
        else if (ce_i && wr && hit_rxp)
            rxp_r <= wb_dat_i[7:0];
    end

    // Interrupt outputs; the pin is released in the receiver role
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_r <= 1'b1;
            irq_oe_r <= 1'b0;
            int_r <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_r <= irq_lvl;
            irq_oe_r <= role_tx;
            int_r <= pending;
        end
    end

    // Derived configuration: delay in cycles and power in dBm
    // The product stays below 2^24 for every table entry at the default rate
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lat_cyc_r <= 24'h00_0000;
            txdbm_r <= lcirq_pkg::DBM_CODE3;
            rxdbm_r <= lcirq_pkg::DBM_CODE0;
        end
        else if (ce_i)
        begin
            lat_cyc_r <= 24'(lat_us(lat_r[1:0], fs_sel_i)) * 24'(LAT_CYC_PER_US);
            txdbm_r <= pwr_dbm(txp_r[1:0]);
            rxdbm_r <= pwr_dbm(rxp_r[1:0]);
        end
    end

    // All outputs come straight from flip-flops
    assign wb_ack_o = bus_r[1]; // One-hot acknowledge state bit, no decode
    assign wb_dat_o = rdat_r;
    assign irq_o = irq_r;
    assign irq_oe_o = irq_oe_r;
    assign int_o = int_r;
    assign latency_code_o = lat_r[1:0];
    assign latency_cycles_o = lat_cyc_r;
    assign tx_power_code_o = txp_r[1:0];
    assign rx_power_code_o = rxp_r[1:0];
    assign tx_power_dbm_o = txdbm_r;
    assign rx_power_dbm_o = rxdbm_r;
endmodule : lcirq_regs
`default_nettype wire

// File: lcirq_pkg.sv
// Shared constants for the link configuration and interrupt register block
package lcirq_pkg;
    // Register indices; the Wishbone byte address is four times the index
    localparam logic [7:0] IDX_INT_FLAGS = 8'h02;
    localparam logic [7:0] IDX_LAT_SEL = 8'h12;
    localparam logic [7:0] IDX_INT_CFG = 8'h13;
    localparam logic [7:0] IDX_TX_PWR = 8'h16;
    localparam logic [7:0] IDX_RX_PWR = 8'h49;
    // Reset values
    localparam logic [7:0] RST_INT_FLAGS = 8'h00;
    localparam logic [7:0] RST_LAT_SEL = 8'h00;
    localparam logic [7:0] RST_INT_CFG = 8'h00;
    localparam logic [7:0] RST_TX_PWR = 8'h03;
    localparam logic [7:0] RST_RX_PWR = 8'h00;
    // Field positions in the flag and config registers
    localparam int BIT_POLARITY = 7;
    localparam int BIT_LINK_BROKEN = 6;
    localparam int BIT_POOR_LINK = 5;
    localparam int BIT_XFER_DONE = 4;
    localparam int BIT_INPUT_CHG = 3;
    // Bits that hold state; all others read as zero
    localparam logic [7:0] MASK_EVENTS = 8'h78;
    localparam logic [7:0] MASK_CFG = 8'hF8;
    // Latency codes
    localparam logic [1:0] LAT_NOMINAL = 2'h0;
    localparam logic [1:0] LAT_HIGH = 2'h1;
    localparam logic [1:0] LAT_SHORT = 2'h2;
    // Sample rate select codes
    localparam logic [1:0] FS_48K = 2'h0;
    localparam logic [1:0] FS_44K1 = 2'h1;
    localparam logic [1:0] FS_32K = 2'h2;
    // End-to-end delays in microseconds, per code and sample rate
    localparam logic [14:0] DLY_NOM_48_US = 15'h30D4;
    localparam logic [14:0] DLY_NOM_44_US = 15'h32C8;
    localparam logic [14:0] DLY_NOM_32_US = 15'h3E80;
    localparam logic [14:0] DLY_HIGH_48_US = 15'h4E20;
    localparam logic [14:0] DLY_HIGH_44_US = 15'h53FC;
    localparam logic [14:0] DLY_HIGH_32_US = 15'h6D60;
    localparam logic [14:0] DLY_SHORT_48_US = 15'h1B58;
    localparam logic [14:0] DLY_SHORT_44_US = 15'h1B58;
    localparam logic [14:0] DLY_SHORT_32_US = 15'h1F40;
    // Clock period and derived cycles per microsecond
    localparam int CLK_PERIOD_PS = 4000;
    localparam int US_PS = 1000000;
    localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS;
    // Output power codes in dBm, signed
    localparam logic [5:0] DBM_CODE0 = 6'h2C;
    localparam logic [5:0] DBM_CODE1 = 6'h36;
    localparam logic [5:0] DBM_CODE2 = 6'h3B;
    localparam logic [5:0] DBM_CODE3 = 6'h00;
    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } lcirq_bus_e;
endpackage : lcirq_pkg

// File: lcirq_sync.sv
// Two-flop synchroniser for a level from another clock domain
`timescale 1ns/1ps
`default_nettype none
module lcirq_sync
(
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Asynchronous level in, synchronised level out
    input wire logic d_i,
    output logic q_o
);
    // First stage, read only by the second stage
    logic meta_r;
    // Second stage, safe to use
    logic sync_r;

    // Both stages freeze with the clock enable like the rest of the block
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else if (ce_i)
        begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end

    assign q_o = sync_r;
endmodule : lcirq_sync
`default_nettype wire

// File: lcirq_regs_props.sv
// Port-level checks for the link configuration and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module lcirq_regs_props
(
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ev_link_broken_i,
    input wire logic ev_poor_link_i,
    input wire logic ev_xfer_done_i,
    input wire logic ev_input_chg_i,
    input wire logic audio_transmitter_role_i,
    input wire logic irq_o,
    input wire logic irq_oe_o,
    input wire logic int_o,
    input wire logic [1:0] latency_code_o,
    input wire logic [1:0] tx_power_code_o
);
    // Taken request, index, landed write, flag read, config write, any event
    wire logic tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    wire logic [7:0] ix = wb_adr_i[9:2];
    wire logic wr = tk & wb_we_i & wb_sel_i[0];
    wire logic rf = tk & ~wb_we_i & (ix == 8'h02);
    wire logic cw = wr & (ix == 8'h13);
    wire logic ev = ev_link_broken_i | ev_poor_link_i | ev_xfer_done_i | ev_input_chg_i;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (tk |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_flag_resv: assert property (wb_ack_o && $past(rf)
        |-> (wb_dat_o & 32'hFFFF_FF87) == 32'h0000_0000)
        else $error("reserved flag bits read nonzero");
    chk_lat_hold: assert property ($changed(latency_code_o) |-> $past(wr && ix == 8'h12))
        else $error("latency code moved without a write");
    chk_txp_hold: assert property ($changed(tx_power_code_o) |-> $past(wr && ix == 8'h16))
        else $error("tx power moved without a write");
    chk_oe_role: assert property (irq_oe_o |-> $past(audio_transmitter_role_i, 3))
        else $error("pin driven outside transmitter role");
    chk_int_rise: assert property ($rose(int_o) |-> $past(ev) || $past(wr) || $past(wr, 2))
        else $error("interrupt rose without a cause");
    chk_int_fall: assert property ($fell(int_o) |-> $past(rf) || $past(wr) || $past(wr, 2))
        else $error("interrupt fell without a read");
    chk_pol_tie: assert property ($changed(int_o) && !$past(cw) && !$past(cw, 2)
        |-> $changed(irq_o))
        else $error("pin level not tied to interrupt");
endmodule : lcirq_regs_props
bind lcirq_regs lcirq_regs_props u_props (.*);
`default_nettype wire

// File: lcirq_link_model.sv
// Link-side event source that pulses the four event lines on request
`timescale 1ns/1ps
`default_nettype none
module lcirq_link_model
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Requested events, in the flag register layout
    input wire logic [7:0] req_i,
    // Event lines toward the block
    output logic [3:0] ev_o
);
    // One cycle of latency, as a registered link monitor would have
    always_ff @(posedge clk_i)
    begin
        ev_o <= rst_i ? 4'h0 : req_i[6:3];
    end
endmodule : lcirq_link_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the link configuration and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Stimulus
    logic clk = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, role = 1, ce = 1;
    logic [9:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0;
    logic [7:0] req = 0;
    logic [1:0] fs = 0;
    // Design outputs
    wire logic [31:0] rdat;
    wire logic ack, irq, oe, intr;
    wire logic [3:0] ev;
    wire logic [1:0] lat, txc, rxc;
    wire logic [23:0] ncyc;
    wire logic [5:0] txd, rxd;
    // Reference model state
    int n_errors = 0, compares = 0, flg = 0, o;
    int rv [256];
    int ix_l [6] = '{'h02, 'h12, 'h13, 'h16, 'h49, 'h20};
    int dly [3][3] = '{'{12500, 13000, 16000}, '{20000, 21500, 28000}, '{7000, 7000, 8000}};
    int dbm [4] = '{-20, -10, -5, 0};
    always #2 clk = ~clk;
    lcirq_link_model link (.clk_i(clk), .rst_i(rst_i), .req_i(req), .ev_o(ev));
    lcirq_regs #(.LAT_CYC_PER_US(1)) dut
    (
        .clk_i(clk), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ev_link_broken_i(ev[3]), .ev_poor_link_i(ev[2]),
        .ev_xfer_done_i(ev[1]), .ev_input_chg_i(ev[0]), .audio_transmitter_role_i(role),
        .fs_sel_i(fs), .irq_o(irq), .irq_oe_o(oe), .int_o(intr), .latency_code_o(lat),
        .latency_cycles_o(ncyc), .tx_power_code_o(txc), .rx_power_code_o(rxc),
        .tx_power_dbm_o(txd), .rx_power_dbm_o(rxd)
    );
    // Compare one result against the model
    task automatic chk(input string n, input int e, input logic [31:0] g);
        compares++;
        if (g !== 32'(e))
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    // Verdict and end of run
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // One classic cycle; events in evm land on the taking edge
    task automatic wb(input logic w, input int ix, input int d, input int evm);
        int i;
        @(posedge clk);
        req <= 8'(evm);
        @(posedge clk);
        req <= 8'h00;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= 10'(ix * 4);
        sel <= 4'h1;
        wdat <= 32'(d);
        // Wait for the answer however long it takes; the watchdog ends a hang
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (ack !== 1'b1);
        chk("ack_wait", 2, i);
        cyc <= 0;
        stb <= 0;
        if (w && ix != 'h02 && ix != 'h20)
            rv[ix] = d & (ix == 'h13 ? 'hF8 : 'hFF);
        if (!w)
            chk("rdata", ix == 'h02 ? flg : rv[ix], rdat);
        if (!w && ix == 'h02)
            flg = 0;
        flg |= evm & 'h78;
    endtask : wb
    // Pins and configuration outputs against the model
    task automatic pins;
        int p, c, f;
        repeat (2) @(posedge clk);
        p = (flg & rv['h13] & 'h78) != 0;
        c = rv['h12] & 3;
        f = fs == 3 ? 0 : fs;
        chk("int", p, intr);
        chk("irq", rv['h13][7] ? p : !p, irq);
        chk("latc", c, lat);
        chk("lat", dly[c == 3 ? 0 : c][f], ncyc);
        chk("txc", rv['h16] & 3, txc);
        chk("rxc", rv['h49] & 3, rxc);
        chk("txd", dbm[rv['h16] & 3] & 'h3F, txd);
        chk("rxd", dbm[rv['h49] & 3] & 'h3F, rxd);
    endtask : pins
    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
    initial
    begin
        rv['h16] = 3;
        void'($urandom(40981));
        repeat (12) @(posedge clk);
        rst_i <= 0;
        foreach (ix_l[k]) wb(0, ix_l[k], 0, 0);
        pins;
        $display("test reset done");
        repeat (6)
        begin
            fs <= 2'($urandom);
            foreach (ix_l[k]) wb(1, ix_l[k], $urandom, 0);
            foreach (ix_l[k]) wb(0, ix_l[k], 0, 0);
            pins;
        end
        wb(1, 'h12, 1, 0);
        pins;
        $display("test config done");
        for (int b = 3; b < 7; b++)
        begin
            o = b == 6 ? 'h08 : 1 << (b + 1);
            wb(1, 'h13, ($urandom & 'h80) | (1 << b), 0);
            wb(0, 'h20, 0, (1 << b) | o);
            pins;
            wb(0, 'h02, 0, o);
            pins;
            wb(0, 'h02, 0, 0);
            pins;
        end
        $display("test interrupts done");
        role <= 0;
        repeat (5) @(posedge clk);
        chk("oe", 0, oe);
        role <= 1;
        repeat (5) @(posedge clk);
        chk("oe", 1, oe);
        $display("test role done");
        // Events while the clock enable is low must leave no flag behind
        ce <= 0;
        req <= 8'h40;
        repeat (3) @(posedge clk);
        req <= 8'h00;
        repeat (3) @(posedge clk);
        ce <= 1;
        pins;
        $display("test enable done");
        wrap_up;
    end
endmodule : testbench
`default_nettype wire
